// >>> verilog/gci_pkg.sv
package gci_pkg;

  // ==========================================================
  // byte codes seen on the data bus
  localparam logic [7:0] CH_EXEC   = 8'h58;  // execute letter
  localparam logic [7:0] CH_FUNC   = 8'h46;  // function letter
  localparam logic [7:0] CH_RANGE  = 8'h52;  // range letter
  localparam logic [7:0] CH_RATE   = 8'h53;  // rate letter
  localparam logic [7:0] CH_SPACE  = 8'h20;  // filler, skipped
  localparam logic [7:0] CH_DIG_LO = 8'h30;
  localparam logic [7:0] CH_DIG_HI = 8'h39;

  // ==========================================================
  // parameter limits and values after reset or clear; trigger mode after reset only
  localparam logic [7:0] FUNC_MAX  = 8'h04;
  localparam logic [7:0] RANGE_MAX = 8'h07;
  localparam logic [7:0] RATE_MAX  = 8'h07;
  localparam logic [2:0] RANGE_DEF = 3'h6;
  localparam logic [2:0] RATE_DEF  = 3'h2;
  localparam logic [2:0] TRIG_DEF  = 3'h6;   // continuous on external
  localparam logic [2:0] continuous_on_execute_trigger = 3'h4;
  localparam logic [2:0] one_shot_on_execute_trigger   = 3'h5;

  // ==========================================================
  // integration times and their cycle counts at the system clock
  localparam real CLK_PERIOD_NS  = 10.0;
  localparam real INTEG_FAST_MS  = 3.33;
  localparam real INTEG_SLOW_MS  = 100.0;
  localparam int  INTEG_FAST_CYC = int'(INTEG_FAST_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  INTEG_SLOW_CYC = int'(INTEG_SLOW_MS * 1.0e6 / CLK_PERIOD_NS);

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] REG_TRIG       = 8'h00;
  localparam logic [7:0] REG_SETTINGS   = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_CLEAR  = 8'h0c;
  localparam logic [7:0] REG_INT_ENABLE = 8'h10;
  localparam int IRQ_EXEC = 0;  // string executed
  localparam int IRQ_ILL  = 1;  // illegal string discarded
  localparam int IRQ_NREM = 2;  // string refused, no remote
  localparam int IRQ_TRIG = 3;  // execute letter triggered
  localparam int IRQ_W    = 4;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    FN_DCV = 3'b000, FN_ACV = 3'b001, FN_OHM = 3'b010,
    FN_DCA = 3'b011, FN_ACA = 3'b100
  } gci_func_t;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00, PS_LETTER = 2'b01, PS_DIGITS = 2'b10
  } gci_pstate_t;

  typedef enum logic [1:0] {
    INTEG_FAST = 2'b00, INTEG_LINE = 2'b01, INTEG_SLOW = 2'b10
  } gci_integ_t;

  typedef struct packed {
    gci_func_t  func;
    logic [2:0] range;
    logic [2:0] rate;
  } gci_settings_t;

  localparam gci_settings_t SET_DEF = '{FN_DCV, RANGE_DEF, RATE_DEF};

  typedef struct packed {
    logic          fv;   // function staged
    logic          rv;   // range staged
    logic          sv;   // rate staged
    gci_settings_t val;
  } gci_pending_t;

  typedef struct packed {
    logic              auto_rng;
    logic [3:0]        mant;   // full scale = mant * 10^exp
    logic signed [4:0] exp;
  } gci_range_info_t;

  typedef struct packed {
    gci_integ_t  integ;
    logic [31:0] integ_cyc;    // zero when line synchronous
    logic [4:0]  samples;
    logic [2:0]  digits;       // n means n and a half digits
  } gci_rate_info_t;

endpackage

// >>> verilog/gci_sync3.sv
`timescale 1ns/10ps
module gci_sync3 import gci_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // pin in, clean level out
  input  wire logic pin_in,
  output      logic level_q
);

  // ==========================================================
  // state
  typedef struct packed {
    logic s1;   // metastable stage, read only by s2
    logic s2;
    logic s3;
    logic lvl;
  } gci_sync_t;

  gci_sync_t st_q;
  gci_sync_t st_d;

  // level follows only once stages two and three agree
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_q = st_q.lvl;

endmodule

// >>> verilog/gci_decode.sv
`timescale 1ns/10ps
module gci_decode import gci_pkg::*;
#(
  parameter int FAST_CYC = INTEG_FAST_CYC,
  parameter int SLOW_CYC = INTEG_SLOW_CYC
)
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  // applied settings
  input  wire gci_settings_t   set_in,
  // decoded measurement setup
  output      gci_range_info_t range_q,
  output      gci_rate_info_t  rate_q
);

  // ==========================================================
  // state
  typedef struct packed {
    gci_range_info_t rng;
    gci_rate_info_t  rte;
  } gci_dec_t;

  gci_dec_t st_q;
  gci_dec_t st_d;

  // full scale exponent of range 1 per function except AC volts, whose range 1 uses -1
  function automatic logic signed [4:0] base_exp(input gci_func_t f);
    unique case (f)
      FN_DCV, FN_ACV: base_exp = -5'sd2;
      FN_OHM:         base_exp = 5'sd1;
      default:        base_exp = -5'sd5;
    endcase
  endfunction

  // table lookup of range and rate
  always_comb
  begin
    st_d = st_q;
    st_d.rng.auto_rng = (set_in.range == 3'h0);
    st_d.rng.mant     = 4'h2;
    st_d.rng.exp = base_exp(set_in.func) + 5'(signed'({2'b00, set_in.range}))
                   - 5'sd1;
    if (set_in.range == 3'h0)
    begin
      st_d.rng.mant = 4'h0;
      st_d.rng.exp  = 5'sd0;
    end
    else if (set_in.func == FN_ACV && set_in.range == 3'h1)
    begin
      st_d.rng.exp = -5'sd1;
    end
    else if (set_in.range >= 3'h6)
    begin
      unique case (set_in.func)
        FN_DCV:
        begin
          st_d.rng.mant = 4'h1;
          st_d.rng.exp  = 5'sd3;
        end
        FN_ACV:
        begin
          st_d.rng.mant = 4'h7;
          st_d.rng.exp  = 5'sd2;
        end
        FN_OHM:
        begin
          st_d.rng.exp = (set_in.range == 3'h7) ? 5'sd7 : 5'sd6;
        end
        default:
        begin
          st_d.rng.exp = 5'sd0;
        end
      endcase
    end
    if (set_in.rate == 3'h0)
    begin
      st_d.rte = '{INTEG_FAST, 32'(FAST_CYC), 5'h01, 3'h3};
    end
    else if (set_in.rate >= 3'h6)
    begin
      st_d.rte = '{INTEG_SLOW, 32'(SLOW_CYC),
                   5'(5'h01 << (set_in.rate - 3'h6)), 3'h5};
    end
    else
    begin
      st_d.rte = '{INTEG_LINE, 32'h0,
                   5'(5'h01 << (set_in.rate - 3'h1)), 3'h4};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '{'{1'b0, 4'h1, 5'sd3},
                '{INTEG_LINE, 32'h0, 5'h02, 3'h4}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign range_q = st_q.rng;
  assign rate_q  = st_q.rte;

endmodule

// >>> verilog/gci_interp.sv
`timescale 1ns/10ps
// Contract
// - remote off: refuse string, flag no remote
// - execute letter carries out buffered commands
// - unexecuted commands wait in buffer
// - execute letter triggers in modes four, five
// - function 0..4 picks measurement, others illegal
// - power-up or clear: function DC volts
// - range 0 auto; 6 and 7 top ranges
// - power-up or clear: range six
// - ranges 1..4 rising decades per function; AC volts range 1 gives the same scale as range 2
// - range 5 gives the 200 scale for volts, 200k for ohms, 0.2 for amps
// - rate 0: 3.33ms, one sample, 3.5 digits
// - rates 1..5: line cycle, 1..16 samples
// - rates 6,7: 100ms, one or two samples
// - letter plus digits, commands may concatenate
// - any illegal part discards whole string
// - power-up or clear: rate two
module gci_interp import gci_pkg::*;
#(
  parameter int FAST_CYC = INTEG_FAST_CYC,
  parameter int SLOW_CYC = INTEG_SLOW_CYC
)
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  // apb register port
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output      logic [31:0]     prdata,
  output      logic            pready,
  output      logic            pslverr,
  // listener data bytes and clears, same clock
  input  wire logic            rx_valid,
  input  wire logic [7:0]      rx_data,
  input  wire logic            dev_clear,
  // remote enable pin
  input  wire logic            ren_pin,
  // measurement setup
  output      gci_settings_t   settings_q,
  output      gci_range_info_t range_q,
  output      gci_rate_info_t  rate_q,
  output      logic            meas_trigger,
  output      logic            err_illegal,
  output      logic            err_no_remote,
  output      logic            irq
);

  // ==========================================================
  // state of the interpreter
  typedef struct packed {
    gci_pstate_t      ps;       // parser position in a command
    logic [7:0]       letter;   // open command letter
    logic [7:0]       param;    // digits so far
    logic             ovf;      // parameter ran past 255
    gci_pending_t     pend;     // command buffer
    logic             bad;      // string holds an illegal part
    logic             nrem;     // string came without remote
    gci_settings_t    cur;      // applied settings
    logic [2:0]       trig;     // trigger mode from software
    logic [IRQ_W-1:0] ists;     // sticky events
    logic [IRQ_W-1:0] ien;      // event enables
    logic [31:0]      rdata;    // read data captured in setup
    logic             addr_ok;  // setup address is mapped
    logic             trg;      // trigger pulse
    logic             e_ill;    // illegal string pulse
    logic             e_nrem;   // no remote pulse
  } gci_state_t;

  gci_state_t st_q;
  gci_state_t st_d;
  logic       ren_lvl;          // remote enable, cleaned

  // ==========================================================
  // helpers
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= CH_DIG_LO) && (c <= CH_DIG_HI);
  endfunction

  // letters the instrument knows; those not handled here are accepted
  // and left to other blocks, so a string mixing them still executes
  function automatic logic is_known(input logic [7:0] c);
    unique case (c)
      8'h41, 8'h42, 8'h46, 8'h47, 8'h4a, 8'h4b, 8'h4d, 8'h50,
      8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h57, 8'h59, 8'h5a:
        is_known = 1'b1;
      default:
        is_known = 1'b0;
    endcase
  endfunction

  function automatic logic is_addr(input logic [7:0] a);
    is_addr = (a == REG_TRIG) || (a == REG_SETTINGS) ||
              (a == REG_INT_STATUS) || (a == REG_INT_CLEAR) ||
              (a == REG_INT_ENABLE);
  endfunction

  // close an open command: stage its parameter in the buffer; param_bad checks it
  function automatic gci_pending_t close_cmd(
    input gci_pending_t p,
    input logic [7:0]   l,
    input logic [7:0]   v
  );
    close_cmd = p;
    unique case (l)
      CH_FUNC:
      begin
        close_cmd.fv       = 1'b1;
        close_cmd.val.func = gci_func_t'(v[2:0]);
      end
      CH_RANGE:
      begin
        close_cmd.rv        = 1'b1;
        close_cmd.val.range = v[2:0];
      end
      CH_RATE:
      begin
        close_cmd.sv       = 1'b1;
        close_cmd.val.rate = v[2:0];
      end
      default:
      begin
        close_cmd = p;
      end
    endcase
  endfunction

  // parameter legality per letter
  function automatic logic param_bad(
    input logic [7:0] l,
    input logic [7:0] v,
    input logic       o
  );
    unique case (l)
      CH_FUNC:  param_bad = o || (v > FUNC_MAX);
      CH_RANGE: param_bad = o || (v > RANGE_MAX);
      CH_RATE:  param_bad = o || (v > RATE_MAX);
      default:  param_bad = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // remote enable passes three stages before use
  gci_sync3 #(
    .RST_VAL (1'b0)
  ) u_ren_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (ren_pin),
    .level_q (ren_lvl)
  );

  // ==========================================================
  // next state: parser, buffer, execute, registers
  always_comb
  begin
    logic [11:0]      acc;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    acc   = 12'h0;
    ev    = '0;
    clr   = '0;
    st_d        = st_q;
    st_d.trg    = 1'b0;
    st_d.e_ill  = 1'b0;
    st_d.e_nrem = 1'b0;

    // clear restores defaults and empties the buffer
    if (dev_clear)
    begin
      st_d.cur  = SET_DEF;
      st_d.pend = '{1'b0, 1'b0, 1'b0, SET_DEF};
      st_d.ps   = PS_IDLE;
      st_d.bad  = 1'b0;
      st_d.nrem = 1'b0;
    end
    // bytes arrive only once addressed with attention false
    else if (rx_valid)
    begin
      // note any byte taken without remote
      if (!ren_lvl)
      begin
        st_d.nrem = 1'b1;
      end
      if (rx_data == CH_SPACE)
      begin
        st_d.ps = st_q.ps;
      end
      else if (is_digit(rx_data))
      begin
        acc = 12'(st_q.param) * 12'd10 + 12'(rx_data - CH_DIG_LO);
        if (st_q.ps == PS_IDLE)
        begin
          st_d.bad = 1'b1;
        end
        else
        begin
          st_d.ps    = PS_DIGITS;
          st_d.param = (acc > 12'h0ff) ? 8'hff : acc[7:0];
          st_d.ovf   = st_q.ovf || (acc > 12'h0ff);
        end
      end
      else
      begin
        // a letter with no digits is illegal
        if (st_q.ps == PS_LETTER)
        begin
          st_d.bad = 1'b1;
        end
        // an out of range parameter spoils the string
        else if (st_q.ps == PS_DIGITS)
        begin
          st_d.bad  = st_q.bad ||
                      param_bad(st_q.letter, st_q.param, st_q.ovf);
          st_d.pend = close_cmd(st_q.pend, st_q.letter, st_q.param);
        end
        if (rx_data == CH_EXEC)
        begin
          st_d.ps = PS_IDLE;
          if (st_d.nrem)
          begin
            ev[IRQ_NREM] = 1'b1;
            st_d.e_nrem  = 1'b1;
          end
          else if (st_d.bad)
          begin
            ev[IRQ_ILL] = 1'b1;
            st_d.e_ill  = 1'b1;
          end
          else
          begin
            ev[IRQ_EXEC] = 1'b1;
            if (st_d.pend.fv)
            begin
              st_d.cur.func = st_d.pend.val.func;
            end
            if (st_d.pend.rv)
            begin
              st_d.cur.range = st_d.pend.val.range;
            end
            if (st_d.pend.sv)
            begin
              st_d.cur.rate = st_d.pend.val.rate;
            end
          end
          // trigger on execute in modes four and five
          if (ren_lvl && (st_q.trig == continuous_on_execute_trigger ||
                          st_q.trig == one_shot_on_execute_trigger))
          begin
            st_d.trg      = 1'b1;
            ev[IRQ_TRIG]  = 1'b1;
          end
          st_d.pend = '{1'b0, 1'b0, 1'b0, SET_DEF};
          st_d.bad  = 1'b0;
          st_d.nrem = 1'b0;
        end
        else if (rx_data >= 8'h41 && rx_data <= 8'h5a)
        begin
          st_d.bad    = st_d.bad || !is_known(rx_data);
          st_d.letter = rx_data;
          st_d.param  = 8'h00;
          st_d.ovf    = 1'b0;
          st_d.ps     = PS_LETTER;
        end
        else
        begin
          st_d.bad = 1'b1;
          st_d.ps  = PS_IDLE;
        end
      end
    end

    // apb setup: decode and capture read data
    if (psel && !penable)
    begin
      st_d.addr_ok = is_addr(paddr);
      unique case (paddr)
        REG_TRIG:       st_d.rdata = {29'h0, st_q.trig};
        REG_SETTINGS:   st_d.rdata = {16'h0, st_q.ps, st_q.bad,
                                      st_q.pend.fv | st_q.pend.rv |
                                      st_q.pend.sv, 1'b0, st_q.cur.rate,
                                      1'b0, st_q.cur.range, 1'b0,
                                      st_q.cur.func};
        REG_INT_STATUS: st_d.rdata = {28'h0, st_q.ists};
        REG_INT_ENABLE: st_d.rdata = {28'h0, st_q.ien};
        default:        st_d.rdata = 32'h0;
      endcase
    end
    // apb access: writes land here
    if (psel && penable && pwrite)
    begin
      unique case (paddr)
        REG_TRIG:       st_d.trig = pwdata[2:0];
        REG_INT_CLEAR:  clr       = pwdata[IRQ_W-1:0];
        REG_INT_ENABLE: st_d.ien  = pwdata[IRQ_W-1:0];
        default:        st_d.trig = st_q.trig;
      endcase
    end
    // a new event beats a clear in the same cycle
    st_d.ists = (st_q.ists & ~clr) | ev;
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '{PS_IDLE, 8'h00, 8'h00, 1'b0,
                '{1'b0, 1'b0, 1'b0, SET_DEF}, 1'b0, 1'b0, SET_DEF,
                TRIG_DEF, '0, '0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // decoded range and rate for the measurement side
  gci_decode #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_decode (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set_in  (st_q.cur),
    .range_q (range_q),
    .rate_q  (rate_q)
  );

  // ==========================================================
  // outputs; zero wait state so the access phase is one cycle
  assign prdata        = st_q.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !st_q.addr_ok;
  assign settings_q    = st_q.cur;
  assign meas_trigger  = st_q.trg;
  assign err_illegal   = st_q.e_ill;
  assign err_no_remote = st_q.e_nrem;
  assign irq           = |(st_q.ists & st_q.ien);

endmodule

// >>> tb/gci_sva.sv
`timescale 1ns/10ps
module gci_sva import gci_pkg::*;
#(
  parameter int FAST_CYC = INTEG_FAST_CYC,
  parameter int SLOW_CYC = INTEG_SLOW_CYC
)
(
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            rst_n,
  // listener bytes and clears
  input wire logic            rx_valid,
  input wire logic [7:0]      rx_data,
  input wire logic            dev_clear,
  // applied setup and pulses
  input wire gci_settings_t   settings_q,
  input wire gci_range_info_t range_q,
  input wire gci_rate_info_t  rate_q,
  input wire logic            meas_trigger,
  input wire logic            err_illegal,
  input wire logic            err_no_remote
);
  // execute byte taken; a clear in the same cycle swallows it
  logic ex;
  assign ex = rx_valid && rx_data == CH_EXEC && !dev_clear;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // settings
  property p_def; $rose(rst_n) |-> settings_q == SET_DEF; endproperty
  a_def: assert property (p_def)
    else $error("settings not default after reset");
  property p_clr; dev_clear |=> settings_q == SET_DEF; endproperty
  a_clr: assert property (p_clr)
    else $error("settings not default after clear");
  property p_hold; !$stable(settings_q) |-> $past(ex || dev_clear); endproperty
  a_hold: assert property (p_hold)
    else $error("settings moved without execute");
  property p_fn; settings_q.func <= FN_ACA; endproperty
  a_fn: assert property (p_fn)
    else $error("function code out of range");

  // ==========================================================
  // refusals and trigger
  property p_ill; err_illegal |-> $past(ex) && $stable(settings_q)
    && !err_no_remote; endproperty
  a_ill: assert property (p_ill)
    else $error("illegal string applied or misplaced");
  property p_nrem; err_no_remote |-> $past(ex) && $stable(settings_q);
  endproperty
  a_nrem: assert property (p_nrem)
    else $error("no remote string applied or misplaced");
  property p_trig; meas_trigger |-> $past(ex); endproperty
  a_trig: assert property (p_trig)
    else $error("trigger without execute byte");

  // ==========================================================
  // decoded setup, one cycle behind the settings
  property p_auto; $past(settings_q.range) == 3'h0 |-> range_q.auto_rng;
  endproperty
  a_auto: assert property (p_auto)
    else $error("range zero not auto");
  property p_fast; $past(settings_q.rate) == 3'h0 |->
    rate_q.integ_cyc == FAST_CYC && rate_q.digits == 3'h3; endproperty
  a_fast: assert property (p_fast)
    else $error("rate zero decode wrong");
  property p_slow; $past(settings_q.rate) == 3'h6 |->
    rate_q.integ_cyc == SLOW_CYC && rate_q.samples == 5'h01; endproperty
  a_slow: assert property (p_slow)
    else $error("rate six decode wrong");
endmodule

bind gci_interp gci_sva #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC))
  gci_sva_inst (.sys_clk, .rst_n, .rx_valid, .rx_data, .dev_clear,
  .settings_q, .range_q, .rate_q, .meas_trigger, .err_illegal,
  .err_no_remote);

// >>> tb/gci_ctl_model.sv
`timescale 1ns/10ps
module gci_ctl_model import gci_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // data bytes and clears toward the listener
  output      logic       rx_valid,
  output      logic [7:0] rx_data,
  output      logic       dev_clear,
  // remote enable line
  output      logic       ren_pin
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    dev_clear = 1'b0;
    ren_pin = 1'b1;
  end

  task send(input string s, input int gap);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
      // slow controller: idle bus shows a changed value, not the byte
      if (gap > 0)
      begin
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data <= ~s[i];
        repeat (gap - 1) @(posedge sys_clk);
      end
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask

  task clear();
    @(posedge sys_clk);
    dev_clear <= 1'b1;
    @(posedge sys_clk);
    dev_clear <= 1'b0;
  endtask

  task set_ren(input logic v);
    @(posedge sys_clk);
    ren_pin <= v;
  endtask
endmodule

// >>> tb/gci_interp_tb.sv
`timescale 1ns/10ps
module gci_interp_tb import gci_pkg::*;;
  // expected outcome of one execute byte
  typedef struct packed {
    gci_settings_t s;
    logic          ill;
    logic          nrem;
    logic          trg;
  } gci_note_t;

  localparam int FCYC = 33;
  localparam int SCYC = 1000;
  logic            sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, rx_data;
  logic [31:0]     pwdata, prdata;
  logic            rx_valid, dev_clear, ren_pin, irq;
  logic            meas_trigger, err_illegal, err_no_remote;
  gci_settings_t   settings_q, cur;
  gci_range_info_t range_q;
  gci_rate_info_t  rate_q;
  gci_note_t       q[$];
  gci_note_t       n;
  logic [2:0]      mode = 3'h6;
  logic            x1 = 1'b0, x2 = 1'b0;
  int              fail_count = 0, total_checks = 0, seed = 93154;
  string           bad[] = '{"F5X", "R8X", "S8X", "2X", "FX", "F1#X", "V1X"};

  gci_interp #(.FAST_CYC(FCYC), .SLOW_CYC(SCYC)) gci_interp_inst (.sys_clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_valid, .rx_data, .dev_clear, .ren_pin, .settings_q,
    .range_q, .rate_q, .meas_trigger, .err_illegal, .err_no_remote, .irq);
  gci_ctl_model gci_ctl_model_inst (.sys_clk, .rx_valid, .rx_data,
    .dev_clear, .ren_pin);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // expected decode of the applied settings
  function automatic gci_range_info_t rng(gci_settings_t s);
    logic [3:0] m;
    logic signed [4:0] r, e;
    r = $signed({2'b00, s.range});
    m = 4'h2;
    case (s.func)
      FN_DCV: e = r - 5'sh03;
      FN_OHM: e = r;
      FN_ACV: e = (r == 5'sh01) ? -5'sh01 : r - 5'sh03;
      default: e = r - 5'sh06;
    endcase
    if (s.range > 3'h5)
      case (s.func)
        FN_DCV: {m, e} = {4'h1, 5'sh03};
        FN_ACV: {m, e} = {4'h7, 5'sh02};
        FN_OHM: e = r;
        default: e = 5'sh00;
      endcase
    if (s.range == 3'h0)
      return '{1'b1, 4'h0, 5'sh00};
    return '{1'b0, m, e};
  endfunction

  function automatic gci_rate_info_t rte(logic [2:0] r);
    gci_rate_info_t v;
    v.integ = (r == 3'h0) ? INTEG_FAST : (r > 3'h5) ? INTEG_SLOW : INTEG_LINE;
    v.integ_cyc = (r == 3'h0) ? FCYC : (r > 3'h5) ? SCYC : 0;
    v.samples = (r == 3'h0 || r == 3'h6) ? 5'h01 : (r == 3'h7) ? 5'h02
      : 5'h01 << (r - 3'h1);
    v.digits = (r == 3'h0) ? 3'h3 : (r > 3'h5) ? 3'h5 : 3'h4;
    return v;
  endfunction

  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // applied settings and pulses against one note
  task chk_note(input gci_note_t e);
    chk({settings_q, err_illegal, err_no_remote, meas_trigger}, e);
  endtask

  // decoded setup against the table for one setting
  task chk_dec(input gci_settings_t s);
    chk({range_q, rate_q}, {rng(s), rte(s.rate)});
  endtask

  task results;
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // apb master: setup, access held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] exp);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k == 20)
    begin
      fail_count++;
      results();
    end
    chk({pslverr, w ? 32'h0 : prdata}, exp);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // send one string and note what its execute byte must do
  task run(input string s, input gci_settings_t e, input logic ill);
    gci_note_t t;
    t.nrem = !ren_pin;
    t.ill = ill && ren_pin;
    t.trg = ren_pin && (mode == continuous_on_execute_trigger ||
                        mode == one_shot_on_execute_trigger);
    t.s = (ill || !ren_pin) ? cur : e;
    cur = t.s;
    q.push_back(t);
    gci_ctl_model_inst.send(s, $unsigned($random(seed)) % 3);
    repeat (3) @(posedge sys_clk);
  endtask

  // monitor: pulses one cycle after execute, decode one more later
  always @(posedge sys_clk)
  begin
    if (x1)
      chk_note(q[0]);
    if (x2)
    begin
      n = q.pop_front();
      chk_dec(n.s);
    end
    x1 <= rx_valid && rx_data == CH_EXEC && !dev_clear;
    x2 <= x1;
  end

  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cur = SET_DEF;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, REG_SETTINGS, 0, {1'b0, 32'h260});
    apb(1'b0, REG_TRIG, 0, {1'b0, 32'h6});
    apb(1'b0, 8'h20, 0, {1'b1, 32'h0});
    apb(1'b1, REG_INT_ENABLE, 32'hf, 0);
    run("F2X", '{FN_OHM, 3'h6, 3'h2}, 1'b0);
    #1 chk(irq, 1'b1);
    apb(1'b0, REG_INT_STATUS, 0, {1'b0, 32'h1});
    apb(1'b1, REG_INT_CLEAR, 32'hf, 0);
    #1 chk(irq, 1'b0);
    gci_ctl_model_inst.send("F3", 1);
    repeat (3) @(posedge sys_clk);
    chk(settings_q, cur);
    run("R5X", '{FN_DCA, 3'h5, 3'h2}, 1'b0);
    // a letter handled elsewhere and a space pass through
    run("Z1 F2X", '{FN_OHM, 3'h5, 3'h2}, 1'b0);
    foreach (bad[i])
      run(bad[i], cur, 1'b1);
    gci_ctl_model_inst.send("F9", 0);
    run("F1X", cur, 1'b1);
    gci_ctl_model_inst.set_ren(1'b0);
    repeat (4) @(posedge sys_clk);
    run("F1X", cur, 1'b0);
    gci_ctl_model_inst.set_ren(1'b1);
    repeat (4) @(posedge sys_clk);
    for (int i = 4; i < 7; i++)
    begin
      apb(1'b1, REG_TRIG, i, 0);
      mode = i[2:0];
      run("F0X", '{FN_DCV, cur.range, cur.rate}, 1'b0);
    end
    run("S007X", '{cur.func, cur.range, 3'h7}, 1'b0);
    for (int f = 0; f < 5; f++)
      for (int r = 0; r < 8; r++)
        run($sformatf("F%0dR%0dS%0dX", f, r, r),
            '{gci_func_t'(f), r[2:0], r[2:0]}, 1'b0);
    gci_ctl_model_inst.send("F1", 0);
    gci_ctl_model_inst.clear();
    cur = SET_DEF;
    run("X", SET_DEF, 1'b0);
    results();
  end

  initial
  begin
    #1000000;
    fail_count++;
    results();
  end
endmodule
